// *** can_mask_pkg.sv ***
// Constants, register map and field layouts for the CAN mask and object control block
package can_mask_pkg;
	// ==========================================================
	// Widths and counts
	localparam int ADDR_W   = 16;
	localparam int DATA_W   = 16;
	localparam int ID_W     = 29;
	localparam int STD_W    = 11;
	localparam int OBJ_NUM  = 15;
	localparam int OBJ_W    = 4;
	localparam int ELEM_NUM = 8;

	// ==========================================================
	// Register offsets (byte addresses of 16-bit words)
	localparam logic [15:0] OFS_STD_MASK  = 16'hEF06;
	localparam logic [15:0] OFS_EXT_HIGH  = 16'hEF08;
	localparam logic [15:0] OFS_EXT_LOW   = 16'hEF0A;
	localparam logic [15:0] OFS_LAST_HIGH = 16'hEF0C;
	localparam logic [15:0] OFS_LAST_LOW  = 16'hEF0E;
	localparam logic [7:0]  OBJ_PAGE      = 8'hEF;
	localparam logic [3:0]  OBJ_CTRL_NIB  = 4'h0;

	// ==========================================================
	// Control element positions and pair codes
	localparam int EL_IRQ    = 0;
	localparam int EL_OBJECT_RX_IRQ_ENABLE   = 1;
	localparam int EL_OBJECT_TX_IRQ_ENABLE   = 2;
	localparam int EL_VALID  = 3;
	localparam int EL_FRESH  = 4;
	localparam int EL_LOST   = 5;
	localparam int EL_OBJECT_TRANSMIT_REQUEST   = 6;
	localparam int EL_RMT    = 7;
	localparam logic [1:0] PAIR_CLR = 2'h1;
	localparam logic [1:0] PAIR_SET = 2'h2;
	// Elements forced inactive in the last object: tx enable, tx request, remote pending
	localparam logic [7:0] LAST_HARD_OFF = 8'hC4;

	// ==========================================================
	// Fixed bits of the mask registers
	localparam logic [4:0]  STD_ONES   = 5'h1F;
	localparam logic [2:0]  LOW_ZEROS  = 3'h0;
	localparam logic [17:0] STD_PAD    = 18'h00000;

	// ==========================================================
	// Register views of a 29-bit mask (index 28 is identifier bit 28)
	function automatic logic [15:0] high_view(input logic [28:0] m);
		high_view = {m[20:18], m[17:13], m[28:21]};
	endfunction : high_view

	function automatic logic [15:0] low_view(input logic [28:0] m);
		low_view = {m[4:0], LOW_ZEROS, m[12:5]};
	endfunction : low_view

	function automatic logic [15:0] std_view(input logic [10:0] m);
		std_view = {m[2:0], STD_ONES, m[10:3]};
	endfunction : std_view
endpackage : can_mask_pkg

// *** object_ctrl_if.sv ***
// Carrier between the top block and one message object control register
`timescale 1ns/1ns
interface object_ctrl_if;
	logic        wr;
	logic [15:0] wdata;
	logic        rxStore;
	logic        remoteHit;
	logic        txDone;
	logic [7:0]  elem;

	modport ctl (input wr, input wdata, input rxStore, input remoteHit, input txDone,
		output elem);
	modport top (output wr, output wdata, output rxStore, output remoteHit, output txDone,
		input elem);
endinterface : object_ctrl_if

// *** object_ctrl.sv ***
// One message object control register built from complementary bit pairs
`timescale 1ns/1ns
module object_ctrl #(
	parameter bit LAST = 1'b0
) (
	input  wire logic   clk,
	object_ctrl_if.ctl  bus
);
	// ==========================================================
	// Element update
	logic [7:0] elem_r;
	logic [7:0] elem_nxt;
	logic [7:0] swSet;
	logic [7:0] swClr;
	logic [7:0] hwSet;
	logic [7:0] hwClr;
	logic [7:0] hardOff;

	assign hardOff = LAST ? can_mask_pkg::LAST_HARD_OFF : 8'h00;

	for (genvar k = 0; k < can_mask_pkg::ELEM_NUM; k++) begin : g_pair
		assign swSet[k] = bus.wr && (bus.wdata[2*k+1 -: 2] == can_mask_pkg::PAIR_SET);
		assign swClr[k] = bus.wr && (bus.wdata[2*k+1 -: 2] == can_mask_pkg::PAIR_CLR);
	end

	always_comb begin
		hwSet = 8'h00;
		hwClr = 8'h00;
		hwSet[can_mask_pkg::EL_IRQ] = (bus.rxStore && elem_r[can_mask_pkg::EL_OBJECT_RX_IRQ_ENABLE])
			|| (bus.txDone && elem_r[can_mask_pkg::EL_OBJECT_TX_IRQ_ENABLE]);
		hwSet[can_mask_pkg::EL_FRESH] = bus.rxStore;
		hwSet[can_mask_pkg::EL_LOST]  = bus.rxStore && elem_r[can_mask_pkg::EL_FRESH];
		hwSet[can_mask_pkg::EL_OBJECT_TRANSMIT_REQUEST]  = bus.remoteHit;
		hwSet[can_mask_pkg::EL_RMT]   = bus.remoteHit;
		// Fresh data written during an update keeps the request alive
		hwClr[can_mask_pkg::EL_OBJECT_TRANSMIT_REQUEST]  = bus.txDone && !elem_r[can_mask_pkg::EL_FRESH];
		hwClr[can_mask_pkg::EL_RMT]   = bus.txDone;
	end

	// Set wins over any clear but the last object's hardwired-off mask, so no event is lost; pending stays until cleared
	assign elem_nxt = (hwSet | swSet | (elem_r & ~swClr & ~hwClr)) & ~hardOff;

	// No reset on purpose: these elements survive a system reset
	always_ff @(posedge clk) begin
		elem_r <= elem_nxt;
	end

	assign bus.elem = elem_r;
endmodule : object_ctrl

// *** can_mask_ctrl.sv ***
// Acceptance masks, object control registers, filtering and transmit selection
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
// Contract
// - Frame extension flag selects standard 11-bit or extended 29-bit global mask.
// - A zero mask bit makes that identifier position match either value.
// - Object 15 has an extra mask over the whole arbitration field.
// - Object 15 effective mask is its own mask ANDed with the global mask.
// - Standard mask holds 11 writable bits; other positions read as ones.
// - Extended mask has 29 writable bits; unused low-register positions read zero.
// - Last-object mask spans 29 bits and works in either identifier format.
// - Fifteen objects, each starting on a 16-byte boundary.
// - Control elements are bit pairs: 01 clears, 10 sets, 11 keeps.
// - Reset leaves every object control element unchanged.
// - Interrupt pending stays set until software clears it.
// - Receive interrupt enable makes a stored frame set interrupt pending.
// - Transmit interrupt enable makes a sent frame set interrupt pending.
// - An object under update is never transmitted.
// - Remote request sets remote pending and request; success clears remote pending, and clears the request only while fresh data is clear.
// - Object 15 transmit elements are hardwired inactive.
// - Lowest numbered valid requesting object is transmitted first.
module can_mask_ctrl #(
	parameter int OBJ_NUM = can_mask_pkg::OBJ_NUM
) (
	input  wire logic                                clk,
	input  wire logic                                srst,
	input  wire logic [can_mask_pkg::ADDR_W-1:0]     addr,
	input  wire logic [can_mask_pkg::DATA_W-1:0]     wdata,
	input  wire logic                                wr,
	input  wire logic                                rd,
	output logic      [can_mask_pkg::DATA_W-1:0]     rdata,
	input  wire logic                                rxValid,
	input  wire logic                                rxExt,
	input  wire logic                                rxRemote,
	input  wire logic [can_mask_pkg::ID_W-1:0]       rxId,
	input  wire logic [OBJ_NUM*can_mask_pkg::ID_W-1:0] objId,
	input  wire logic [OBJ_NUM-1:0]                  objExt,
	input  wire logic [OBJ_NUM-1:0]                  objDir,
	input  wire logic                                txDone,
	input  wire logic [can_mask_pkg::OBJ_W-1:0]      txDoneObj,
	output logic                                     rxAccept,
	output logic      [can_mask_pkg::OBJ_W-1:0]      rxObj,
	output logic                                     txReq,
	output logic      [can_mask_pkg::OBJ_W-1:0]      txObj,
	output logic      [OBJ_NUM-1:0]                  irqPending
);
	localparam int OW = can_mask_pkg::OBJ_W;

	if (OBJ_NUM < 1 || OBJ_NUM > can_mask_pkg::OBJ_NUM) begin : g_chk
		$error("OBJ_NUM must lie between 1 and 15");
	end

	// ==========================================================
	// Mask registers
	logic [10:0] stdMask_r;
	logic [28:0] extMask_r;
	logic [28:0] lastMask_r;
	logic [10:0] stdMask_nxt;
	logic [28:0] extMask_nxt;
	logic [28:0] lastMask_nxt;

	wire selStd      = (addr == can_mask_pkg::OFS_STD_MASK);
	wire selExtHigh  = (addr == can_mask_pkg::OFS_EXT_HIGH);
	wire selExtLow   = (addr == can_mask_pkg::OFS_EXT_LOW);
	wire selLastHigh = (addr == can_mask_pkg::OFS_LAST_HIGH);
	wire selLastLow  = (addr == can_mask_pkg::OFS_LAST_LOW);
	wire [OW-1:0] objSel = addr[7:4];
	wire selObj = (addr[15:8] == can_mask_pkg::OBJ_PAGE)
		&& (addr[3:0] == can_mask_pkg::OBJ_CTRL_NIB)
		&& (objSel != 4'h0) && (32'(objSel) <= OBJ_NUM);

	assign stdMask_nxt = (wr && selStd) ? {wdata[7:0], wdata[15:13]} : stdMask_r;
	assign extMask_nxt = (wr && selExtHigh) ?
		{wdata[7:0], wdata[15:13], wdata[12:8], extMask_r[12:0]} :
		(wr && selExtLow) ? {extMask_r[28:13], wdata[7:0], wdata[15:11]} : extMask_r;
	assign lastMask_nxt = (wr && selLastHigh) ?
		{wdata[7:0], wdata[15:13], wdata[12:8], lastMask_r[12:0]} :
		(wr && selLastLow) ? {lastMask_r[28:13], wdata[7:0], wdata[15:11]} : lastMask_r;

	// Reset to all don't-care, so every identifier matches until software sets the masks
	always_ff @(posedge clk) begin
		if (srst) begin
			stdMask_r  <= 11'h000;
			extMask_r  <= 29'h00000000;
			lastMask_r <= 29'h00000000;
		end else begin
			stdMask_r  <= stdMask_nxt;
			extMask_r  <= extMask_nxt;
			lastMask_r <= lastMask_nxt;
		end
	end

	// ==========================================================
	// Per-object filtering and control
	logic [7:0]       objElem [OBJ_NUM];
	logic [OBJ_NUM-1:0] rxHit;
	logic [OBJ_NUM-1:0] txCand;
	logic [OBJ_NUM-1:0] objValid;
	logic [OBJ_NUM-1:0] objBlocked;
	logic [OBJ_NUM-1:0] rxStoreVec;
	logic [OBJ_NUM-1:0] remoteVec;
	logic [OBJ_NUM-1:0] txDoneVec;
	logic [OW-1:0]      rxWin;
	logic [OW-1:0]      txWin;
	logic               rxAny;
	logic               txAny;

	wire [28:0] globalMask = rxExt ? extMask_r : {stdMask_r, can_mask_pkg::STD_PAD};

	for (genvar i = 0; i < OBJ_NUM; i++) begin : g_obj
		object_ctrl_if ctl ();
		wire [28:0] oid = objId[i*can_mask_pkg::ID_W +: can_mask_pkg::ID_W];
		// Elaboration constant, since it also sets the object's parameter
		localparam bit IS_LAST = (i == can_mask_pkg::OBJ_NUM - 1);
		wire [28:0] effMask = IS_LAST ? (globalMask & lastMask_r) : globalMask;
		wire idMatch = (((rxId ^ oid) & effMask) == 29'h00000000);
		assign objValid[i] = objElem[i][can_mask_pkg::EL_VALID];
		// The shared element means update in progress only for transmit objects
		assign objBlocked[i] = objDir[i] && objElem[i][can_mask_pkg::EL_LOST];
		assign rxHit[i] = objValid[i] && idMatch && (objExt[i] == rxExt)
			&& (objDir[i] == rxRemote) && !(IS_LAST && rxRemote);
		assign txCand[i] = objValid[i] && objElem[i][can_mask_pkg::EL_OBJECT_TRANSMIT_REQUEST]
			&& !objBlocked[i] && !IS_LAST;
		assign rxStoreVec[i] = rxValid && rxAny && (rxWin == OW'(i + 1)) && !rxRemote;
		assign remoteVec[i]  = rxValid && rxAny && (rxWin == OW'(i + 1)) && rxRemote;
		assign txDoneVec[i]  = txDone && (txDoneObj == OW'(i + 1));
		assign ctl.wr        = wr && selObj && (objSel == OW'(i + 1));
		assign ctl.wdata     = wdata;
		assign ctl.rxStore   = rxStoreVec[i];
		assign ctl.remoteHit = remoteVec[i];
		assign ctl.txDone    = txDoneVec[i];
		assign objElem[i]    = ctl.elem;
		object_ctrl #(
			.LAST (IS_LAST)
		) u_obj (
			.clk (clk),
			.bus (ctl)
		);
	end

	// Lowest object number wins both for reception and for transmission
	always_comb begin
		rxAny = 1'b0;
		txAny = 1'b0;
		rxWin = 4'h0;
		txWin = 4'h0;
		for (int j = OBJ_NUM - 1; j >= 0; j--) begin
			if (rxHit[j]) begin
				rxAny = 1'b1;
				rxWin = OW'(j + 1);
			end
			if (txCand[j]) begin
				txAny = 1'b1;
				txWin = OW'(j + 1);
			end
		end
	end

	// ==========================================================
	// Read path
	logic [15:0] objRead;
	logic [15:0] rdValue;

	always_comb begin
		objRead = 16'h0000;
		for (int j = 0; j < OBJ_NUM; j++) begin
			if (objSel == OW'(j + 1)) begin
				for (int k = 0; k < can_mask_pkg::ELEM_NUM; k++) begin
					objRead[2*k +: 2] = {objElem[j][k], !objElem[j][k]};
				end
			end
		end
	end

	assign rdValue = selStd      ? can_mask_pkg::std_view(stdMask_r) :
		selExtHigh  ? can_mask_pkg::high_view(extMask_r) :
		selExtLow   ? can_mask_pkg::low_view(extMask_r) :
		selLastHigh ? can_mask_pkg::high_view(lastMask_r) :
		selLastLow  ? can_mask_pkg::low_view(lastMask_r) :
		selObj      ? objRead : 16'h0000;

	// ==========================================================
	// Output flops
	logic [OBJ_NUM-1:0] irqVec;

	for (genvar i = 0; i < OBJ_NUM; i++) begin : g_irq
		assign irqVec[i] = objElem[i][can_mask_pkg::EL_IRQ];
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata      <= 16'h0000;
			rxAccept   <= 1'b0;
			rxObj      <= 4'h0;
			txReq      <= 1'b0;
			txObj      <= 4'h0;
			irqPending <= '0;
		end else begin
			rdata      <= rd ? rdValue : 16'h0000;
			rxAccept   <= rxValid && rxAny;
			rxObj      <= (rxValid && rxAny) ? rxWin : rxObj;
			txReq      <= txAny;
			txObj      <= txWin;
			irqPending <= irqVec;
		end
	end

	// ==========================================================
	// Checks
	wire [OW-1:0] rxIdx = rxObj - 4'h1;
	wire [OW-1:0] txIdx = txObj - 4'h1;
	wire swClrIrq0 = g_obj[0].ctl.wr && (wdata[1:0] == can_mask_pkg::PAIR_CLR);

	valid_accept_a: assert property (@(posedge clk) disable iff (srst)
		rxAccept |-> ((($past(objValid) >> rxIdx) & OBJ_NUM'(1)) != '0))
		else $error("accepted frame into invalid object");
	lowest_tx_a: assert property (@(posedge clk) disable iff (srst)
		txReq |-> (($past(txCand) & ((15'h0001 << txIdx) - 15'h0001)) == 15'h0000))
		else $error("lower requesting object skipped");
	update_hold_a: assert property (@(posedge clk) disable iff (srst)
		txReq |-> ((($past(objBlocked) >> txIdx) & OBJ_NUM'(1)) == '0))
		else $error("object under update selected for transmit");
	last_no_tx_a: assert property (@(posedge clk) disable iff (srst)
		txReq |-> (txObj != 4'hF))
		else $error("last object selected for transmit");
	irq_sticky_a: assert property (@(posedge clk) disable iff (srst)
		(objElem[0][can_mask_pkg::EL_IRQ] && !swClrIrq0) |=> objElem[0][can_mask_pkg::EL_IRQ])
		else $error("interrupt pending dropped without clear");
	rx_irq_a: assert property (@(posedge clk) disable iff (srst)
		(rxStoreVec[0] && objElem[0][can_mask_pkg::EL_OBJECT_RX_IRQ_ENABLE]) |=> ##1 irqPending[0])
		else $error("receive did not raise interrupt pending");
	tx_irq_a: assert property (@(posedge clk) disable iff (srst)
		(txDoneVec[1] && objElem[1][can_mask_pkg::EL_OBJECT_TX_IRQ_ENABLE]) |=> objElem[1][can_mask_pkg::EL_IRQ])
		else $error("transmit did not raise interrupt pending");
	remote_set_a: assert property (@(posedge clk) disable iff (srst)
		remoteVec[1] |=> (objElem[1][can_mask_pkg::EL_OBJECT_TRANSMIT_REQUEST] && objElem[1][can_mask_pkg::EL_RMT]))
		else $error("remote request not recorded");
	lost_flag_a: assert property (@(posedge clk) disable iff (srst)
		(rxStoreVec[0] && objElem[0][can_mask_pkg::EL_FRESH]) |=> objElem[0][can_mask_pkg::EL_LOST])
		else $error("overwrite not flagged");
	std_ones_a: assert property (@(posedge clk) disable iff (srst)
		(rd && selStd) |=> (rdata[12:8] == can_mask_pkg::STD_ONES))
		else $error("standard mask fixed bits not ones");
	low_zero_a: assert property (@(posedge clk) disable iff (srst)
		(rd && selExtLow) |=> (rdata[10:8] == can_mask_pkg::LOW_ZEROS))
		else $error("extended low mask unused bits not zero");
	pair_read_a: assert property (@(posedge clk) disable iff (srst)
		(rd && selObj) |=> (rdata[1] != rdata[0]))
		else $error("control pair read back reserved code");

	rx_accept_c: cover property (@(posedge clk) disable iff (srst) rxAccept);
	last_accept_c: cover property (@(posedge clk) disable iff (srst) rxAccept && (rxObj == 4'hF));
	tx_req_c: cover property (@(posedge clk) disable iff (srst) txReq ##1 txDone);
endmodule : can_mask_ctrl

// *** can_bus_node.sv ***
// Far-side CAN node model: delivers received frames and confirms transmissions
`timescale 1ns/1ns
module can_bus_node (
	input  wire logic        clk,
	input  wire logic        ackEn,
	input  wire logic        txReq,
	input  wire logic [3:0]  txObj,
	output logic             rxValid,
	output logic             rxExt,
	output logic             rxRemote,
	output logic [28:0]      rxId,
	output logic             txDone,
	output logic [3:0]       txDoneObj
);
	logic [1:0] holdOff = 2'h0;
	logic [1:0] waitCnt = 2'h0;
	logic [1:0] lag     = 2'h0;

	initial begin
		rxValid = 1'b0;
		rxExt = 1'b0;
		rxRemote = 1'b0;
		rxId = 29'h1FFFFFFF;
		txDone = 1'b0;
		txDoneObj = 4'h0;
	end

	// ==========================================================
	// Frame delivery
	// Lines show the inverse after the frame so stale values never look valid
	task automatic send(input logic ext, input logic remote, input logic [28:0] id);
		@(posedge clk);
		rxValid  <= 1'b1;
		rxExt    <= ext;
		rxRemote <= remote;
		rxId     <= id;
		@(posedge clk);
		rxValid  <= 1'b0;
		rxExt    <= ~ext;
		rxRemote <= ~remote;
		rxId     <= ~id;
	endtask : send

	// ==========================================================
	// Transmit confirmation
	// Delay grows 0..3 cycles per frame; back off until the request can drop
	always @(posedge clk) begin
		txDone <= 1'b0;
		if (holdOff != 2'h0) begin
			holdOff <= holdOff - 2'h1;
		end else if (ackEn && txReq) begin
			waitCnt <= waitCnt + 2'h1;
			if (waitCnt == lag) begin
				txDone    <= 1'b1;
				txDoneObj <= txObj;
				waitCnt   <= 2'h0;
				lag       <= lag + 2'h1;
				holdOff   <= 2'h3;
			end
		end
	end
endmodule : can_bus_node

// *** tb_can_mask_ctrl.sv ***
// Self-checking bench for the CAN mask and object control block
`timescale 1ns/1ns
`define CHK(act, exp) begin \
	checkCount++; \
	if ((act) !== (exp)) begin \
		errorCnt++; \
		$display("[ERR] %0t got %h expected %h", $time, (act), (exp)); \
	end \
end
module tb_can_mask_ctrl;
	localparam int NO = can_mask_pkg::OBJ_NUM;
	localparam logic [28:0] ID15 = 29'h1234567;
	logic              clk = 1'b0;
	logic              srst = 1'b1;
	logic [15:0]       addr = 16'h0000;
	logic [15:0]       wdata = 16'h0000;
	logic              wr = 1'b0;
	logic              rd = 1'b0;
	logic              ackEn = 1'b0;
	logic [NO*29-1:0]  objId;
	logic [NO-1:0]     objExt = 15'h4000;
	logic [NO-1:0]     objDir = 15'h0006;
	logic [15:0]       rdata;
	logic [28:0]       rxId;
	logic [3:0]        txDoneObj, rxObj, txObj;
	logic [NO-1:0]     irqPending;
	logic              rxValid, rxExt, rxRemote, txDone, rxAccept, txReq;
	int                errorCnt = 0;
	int                checkCount = 0;

	always #2 clk = ~clk;

	can_mask_ctrl dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .rxValid(rxValid), .rxExt(rxExt), .rxRemote(rxRemote), .rxId(rxId),
		.objId(objId), .objExt(objExt), .objDir(objDir), .txDone(txDone),
		.txDoneObj(txDoneObj), .rxAccept(rxAccept), .rxObj(rxObj), .txReq(txReq),
		.txObj(txObj), .irqPending(irqPending));
	can_bus_node node (.clk(clk), .ackEn(ackEn), .txReq(txReq), .txObj(txObj),
		.rxValid(rxValid), .rxExt(rxExt), .rxRemote(rxRemote), .rxId(rxId),
		.txDone(txDone), .txDoneObj(txDoneObj));

	// ==========================================================
	// Helpers
	function automatic logic [15:0] pairs(input logic [7:0] setEl, input logic [7:0] clrEl);
		logic [15:0] w;
		w = 16'hFFFF;
		for (int k = 0; k < 8; k++) begin
			if (setEl[k])
				w[2*k +: 2] = 2'h2;
			if (clrEl[k])
				w[2*k +: 2] = 2'h1;
		end
		return w;
	endfunction : pairs

	function automatic logic [15:0] oa(input int n);
		return {8'hEF, 4'(n), 4'h0};
	endfunction : oa

	task automatic reportAndStop();
		if (errorCnt == 0 && checkCount > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : reportAndStop

	task automatic ticks(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : ticks

	task automatic wrReg(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : wrReg

	task automatic rdReg(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		`CHK(rdata, exp)
	endtask : rdReg

	task automatic frame(input logic ext, input logic rem, input logic [28:0] id,
		input logic acc, input logic [3:0] obj);
		node.send(ext, rem, id);
		#1;
		`CHK(rxAccept, acc)
		if (acc)
			`CHK(rxObj, obj)
	endtask : frame

	// Bounded wait; a lost confirmation ends the run
	task automatic waitDone(input logic [3:0] obj);
		int i;
		for (i = 0; i < 50 && txDone !== 1'b1; i++)
			ticks(1);
		`CHK(1'(i < 50), 1'b1)
		if (i >= 50)
			reportAndStop();
		`CHK(txDoneObj, obj)
		ticks(1);
	endtask : waitDone

	initial begin
		repeat (20000) @(posedge clk);
		errorCnt++;
		reportAndStop();
	end

	// ==========================================================
	// Main sequence
	initial begin
		for (int n = 1; n <= NO; n++)
			objId[(n-1)*29 +: 29] = 29'(n) << 18;
		objId[(NO-1)*29 +: 29] = ID15;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		for (int n = 1; n <= NO; n++)
			wrReg(oa(n), 16'h5555);
		wrReg(16'hEF06, 16'hFFFF);
		rdReg(16'hEF06, 16'hFFFF);
		wrReg(16'hEF06, 16'h0000);
		rdReg(16'hEF06, 16'h1F00);
		wrReg(16'hEF0A, 16'hFFFF);
		rdReg(16'hEF0A, 16'hF8FF);
		rdReg(16'hEF00, 16'h0000);
		wrReg(16'hEF06, 16'hFFFF);
		wrReg(16'hEF08, 16'hFFFF);
		wrReg(16'hEF0C, 16'hFFFF);
		wrReg(16'hEF0E, 16'hFFFF);
		wrReg(oa(1), pairs(8'h0A, 8'h00));
		rdReg(oa(1), 16'h5599);
		wrReg(oa(1), 16'hFFFF);
		rdReg(oa(1), 16'h5599);
		frame(1'b0, 1'b0, 29'h0040000, 1'b1, 4'h1);
		ticks(1);
		`CHK(irqPending[0], 1'b1)
		rdReg(oa(1), 16'h569A);
		frame(1'b0, 1'b0, 29'h0040000, 1'b1, 4'h1);
		rdReg(oa(1), 16'h5A9A);
		frame(1'b0, 1'b0, 29'h0000000, 1'b0, 4'h0);
		wrReg(16'hEF06, 16'h0000);
		frame(1'b0, 1'b0, 29'h0000000, 1'b1, 4'h1);
		frame(1'b1, 1'b0, 29'h0040000, 1'b0, 4'h0);
		`CHK(irqPending[0], 1'b1)
		wrReg(oa(1), pairs(8'h00, 8'h01));
		ticks(1);
		`CHK(irqPending[0], 1'b0)
		wrReg(oa(1), pairs(8'h00, 8'h08));
		frame(1'b0, 1'b0, 29'h0040000, 1'b0, 4'h0);
		// Last object: own mask opens the low identifier bits
		wrReg(oa(15), pairs(8'h08, 8'h00));
		wrReg(16'hEF0E, 16'h0000);
		frame(1'b1, 1'b0, ID15 ^ 29'h0000ABC, 1'b1, 4'hF);
		frame(1'b1, 1'b0, ID15 ^ 29'h0100000, 1'b0, 4'h0);
		wrReg(16'hEF0E, 16'hFFFF);
		wrReg(16'hEF0A, 16'h0000);
		frame(1'b1, 1'b0, ID15 ^ 29'h0000ABC, 1'b1, 4'hF);
		wrReg(oa(15), pairs(8'hC4, 8'h00));
		rdReg(oa(15), 16'h5A95);
		// Transmit objects 2 and 3, object 2 held back while updated
		wrReg(oa(2), pairs(8'h6C, 8'h00));
		ticks(2);
		`CHK(txReq, 1'b0)
		wrReg(oa(3), pairs(8'h48, 8'h00));
		ticks(1);
		`CHK(txObj, 4'h3)
		wrReg(oa(2), pairs(8'h00, 8'h20));
		ticks(1);
		`CHK(txObj, 4'h2)
		ackEn <= 1'b1;
		waitDone(4'h2);
		waitDone(4'h3);
		ackEn <= 1'b0;
		rdReg(oa(2), 16'h55A6);
		`CHK(irqPending[1], 1'b1)
		frame(1'b0, 1'b1, 29'h0080000, 1'b1, 4'h2);
		rdReg(oa(2), 16'hA5A6);
		ackEn <= 1'b1;
		waitDone(4'h2);
		ackEn <= 1'b0;
		rdReg(oa(2), 16'h55A6);
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rdReg(oa(3), 16'h5595);
		reportAndStop();
	end
endmodule : tb_can_mask_ctrl
